// *** design/phy_ctrl_map.vh ***
/*
 * Constants for the transceiver control block: register offsets, bit
 * positions, reset values, timing figures and 4B/5B code groups.
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef PHY_CTRL_MAP_VH
`define PHY_CTRL_MAP_VH

// ****************************************************
// Register offsets
// ****************************************************
`define REG_CONTROL 4'h0
`define REG_MODE_CTRL 4'h1
`define REG_STATUS 4'h2
`define REG_STRAPS 4'h3

// ****************************************************
// Control register fields
// ****************************************************
`define CTL_SOFT_RESET 4'h0
`define CTL_POWER_DOWN 4'h1
`define CTL_ISOLATE 4'h2
`define CTL_SPEED_100 4'h3
`define CTL_FULL_DUPLEX 4'h4
`define CTL_AUTONEG 4'h5
`define CTL_RESET_VALUE 16'h0028

// ****************************************************
// Mode control / status fields
// ****************************************************
`define MCS_EDPD_EN 4'h0
`define MCS_ENERGY 4'h1
`define MCS_IRQ_MASK 4'h2
`define MCS_STICKY 4'h3
`define MCS_REPEATER 4'h4
`define MCS_RESET_VALUE 16'h0000

// ****************************************************
// Status register fields
// ****************************************************
`define STS_ENERGY_EVT 4'h0
`define STS_LINK 4'h1
`define STS_CRS 4'h2
`define STS_POWERED 4'h3
`define STS_FAST_RMII 4'h4

// ****************************************************
// Timing figures
// ****************************************************
`define CLK_HZ 20000000
`define SLOW_WINDOW_NS 16000
`define SOFT_RESET_NS 1000
`define BLINK_HZ 10
`define CLK_PERIOD_NS 50

// ****************************************************
// Five-bit code groups, sent msb first
// ****************************************************
`define SYM_J 5'h18
`define SYM_K 5'h11
`define SYM_T 5'h0d
`define SYM_R 5'h07
`define SYM_IDLE 5'h1f

`endif

// *** design/phy_clock_led_power_crs_control.v ***
/*
 * Control logic of a 10/100 RMII transceiver: strap capture, shared
 * interrupt / reference-clock pin, indicators, power-down, isolation,
 * resets and carrier sense from the encoded receive bit stream.
 * Assumes clk at 20 MHz; pins and the reference clock are asynchronous.
 */
// The implementer's own choices: the placing of the registers and strobed register access.
// Behaviour
// - Latch clock-pin strap at power-on and reset release; power-on reset loads the pull-up default instead
// - Strap low outputs clock; high gives interrupt
// - Clock-output mode disables the interrupt entirely
// - Clock-output mode uses 25 MHz source only
// - Transmit on reference clock; receive through elasticity; here transmit and receive pins only pass the clk synchronisers
// - Link indicator on with link, blinks on carrier
// - Speed indicator on at 100, off otherwise
// - Link indicator polarity follows regulator strap
// - Speed indicator polarity follows clock-pin strap
// - Power-down bit; clearing it resets transceiver
// - Energy-detect power-down without energy stops transmit
// - Energy returns: flag, power up, interrupt
// - Isolate ignores transmit inputs, resets to zero
// - Resets clear registers except sticky on soft; soft reset here also keeps the energy event flag
// - Slow RMII rate for 16 us after reset
// - Soft reset self-clears within half a second
// - Repeater or full duplex: receive-only carrier
// - Two non-contiguous zeros in ten bits start carrier
// - Ten ones before start delimiter end carrier
// - After J/K hold until T/R or idle pair
// - Repeater mode carrier from receive only
`timescale 1ns/100ps
`default_nettype none
`include "phy_ctrl_map.vh"

module phy_clock_led_power_crs_control #(
    parameter integer BLINK_CYCLES = `CLK_HZ / (2 * `BLINK_HZ),
    parameter integer SLOW_CYCLES = (`SLOW_WINDOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Pins from outside, asynchronous
    input wire hw_reset_n,
    input wire clock_pin_mode_strap,
    input wire regulator_off_strap,
    input wire clock_input_pin,
    input wire link_valid,
    input wire line_energy,
    input wire rx_bit,
    input wire rx_bit_valid,
    input wire tx_en,
    input wire [1:0] txd,
    input wire tx_er,
    // Register port
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    // Shared pin and indicators
    output wire shared_irq_clock_pin,
    output wire shared_irq_clock_pin_oe,
    output wire link_activity_indicator,
    output wire speed_indicator,
    // Transceiver side
    output wire tx_en_gated,
    output wire [1:0] txd_gated,
    output wire tx_er_gated,
    output wire carrier_sense,
    output wire core_powered,
    output wire rmii_fast
);

// ****************************************************
// Input synchronisers
// ****************************************************
localparam NSYNC = 11;
reg [NSYNC-1:0] s1_ff;
reg [NSYNC-1:0] s2_ff;
wire [NSYNC-1:0] raw_in = {tx_er, txd, tx_en, rx_bit_valid, rx_bit, line_energy,
    link_valid, clock_input_pin, clock_pin_mode_strap, hw_reset_n};

// Two flops per pin; the first stage feeds only the second
always @(posedge clk) begin
    s1_ff <= raw_in;
    s2_ff <= s1_ff;
end

wire hwr_n_s = s2_ff[0];
wire strap_s = s2_ff[1];
wire refin_s = s2_ff[2];
wire link_s = s2_ff[3];
wire energy_s = s2_ff[4];
wire rxb_s = s2_ff[5];
wire rxv_s = s2_ff[6];
wire txen_s = s2_ff[7];
wire [1:0] txd_s = s2_ff[9:8];
wire txer_s = s2_ff[10];
reg reg_s1_ff;
reg reg_s2_ff;
always @(posedge clk) begin
    reg_s1_ff <= regulator_off_strap;
    reg_s2_ff <= reg_s1_ff;
end

// ****************************************************
// Reset sources and strap latch
// ****************************************************
reg hwr_d_ff;
reg clk_strap_ff;
reg reg_strap_ff;
wire hw_rise = hwr_n_s & ~hwr_d_ff;
wire hw_in_reset = ~rst_n | ~hwr_n_s;

// Straps take pull defaults in power-on reset and are sampled on each rising edge of hardware reset
always @(posedge clk) begin
    hwr_d_ff <= hwr_n_s;
    if (!rst_n) begin
        clk_strap_ff <= 1'b1; // Pull-up default: interrupt mode
        reg_strap_ff <= 1'b0;
    end else if (hw_rise) begin
        clk_strap_ff <= strap_s;
        reg_strap_ff <= reg_s2_ff;
    end
end

// ****************************************************
// Registers
// ****************************************************
reg [15:0] ctl_ff;
reg [15:0] mcs_ff;
reg energy_evt_ff;
reg sticky_ff;
reg pd_d_ff;
reg [31:0] srst_cnt_ff;
reg [15:0] slow_cnt_ff;
wire wr_ctl = reg_wr & (reg_addr == `REG_CONTROL);
wire wr_mcs = reg_wr & (reg_addr == `REG_MODE_CTRL);
wire soft_req = wr_ctl & reg_wdata[`CTL_SOFT_RESET];
wire pd_clear = pd_d_ff & ~ctl_ff[`CTL_POWER_DOWN];
wire edpd_off = mcs_ff[`MCS_EDPD_EN] & ~energy_s;
wire powered = ~ctl_ff[`CTL_POWER_DOWN] & ~edpd_off;
wire energy_rise;
reg energy_d_ff;
assign energy_rise = energy_s & ~energy_d_ff;

// Control register: hardware reset clears all, soft reset keeps sticky
always @(posedge clk) begin
    pd_d_ff <= ctl_ff[`CTL_POWER_DOWN];
    energy_d_ff <= energy_s;
    if (hw_in_reset) begin
        ctl_ff <= `CTL_RESET_VALUE;
        mcs_ff <= `MCS_RESET_VALUE;
        sticky_ff <= 1'b0;
    end else if (soft_req) begin
        ctl_ff <= `CTL_RESET_VALUE | 16'h0001;
        mcs_ff <= `MCS_RESET_VALUE;
    end else begin
        if (wr_ctl)
            ctl_ff <= reg_wdata & ~16'h0001;
        else if (srst_cnt_ff == 32'h0000_0001)
            ctl_ff[`CTL_SOFT_RESET] <= 1'b0; // Self-clearing
        if (wr_mcs) begin
            mcs_ff <= reg_wdata;
            sticky_ff <= reg_wdata[`MCS_STICKY];
        end
    end
end

// Soft-reset completion timer, well under half a second
localparam integer SRST_CYCLES = `SOFT_RESET_NS / `CLK_PERIOD_NS;
always @(posedge clk) begin
    if (hw_in_reset)
        srst_cnt_ff <= 32'h0000_0000;
    else if (soft_req)
        srst_cnt_ff <= SRST_CYCLES;
    else if (srst_cnt_ff != 32'h0000_0000)
        srst_cnt_ff <= srst_cnt_ff - 32'h0000_0001;
end

// Energy event flag; a new event wins over a clear by read
always @(posedge clk) begin
    if (hw_in_reset)
        energy_evt_ff <= 1'b0;
    else if (energy_rise && mcs_ff[`MCS_EDPD_EN])
        energy_evt_ff <= 1'b1;
    else if (reg_rd && reg_addr == `REG_STATUS)
        energy_evt_ff <= 1'b0;
end

// Any reset, soft reset or leaving power-down restarts the slow window
wire core_restart = hw_in_reset | soft_req | pd_clear;
always @(posedge clk) begin
    if (core_restart)
        slow_cnt_ff <= SLOW_CYCLES[15:0];
    else if (slow_cnt_ff != 16'h0000)
        slow_cnt_ff <= slow_cnt_ff - 16'h0001;
end
assign rmii_fast = (slow_cnt_ff == 16'h0000) & ctl_ff[`CTL_AUTONEG];
assign core_powered = powered;

// Register read data one cycle after the strobe
always @(posedge clk) begin
    if (!rst_n)
        reg_rdata <= 16'h0000;
    else if (reg_rd) begin
        case (reg_addr)
            `REG_CONTROL: reg_rdata <= ctl_ff;
            `REG_MODE_CTRL: reg_rdata <= {mcs_ff[15:4], sticky_ff, mcs_ff[2],
                energy_s, mcs_ff[0]};
            `REG_STATUS: reg_rdata <= {11'h000, rmii_fast, powered, carrier_sense,
                link_s, energy_evt_ff};
            `REG_STRAPS: reg_rdata <= {14'h0000, reg_strap_ff, clk_strap_ff};
            default: reg_rdata <= 16'h0000;
        endcase
    end
end

// ****************************************************
// Transmit gating
// ****************************************************
// Isolation or power-down blocks the MAC transmit inputs
wire tx_pass = ~ctl_ff[`CTL_ISOLATE] & powered;
assign tx_en_gated = tx_pass & txen_s;
assign txd_gated = tx_pass ? txd_s : 2'b00;
assign tx_er_gated = tx_pass & txer_s;

// ****************************************************
// Shared pin: reference clock or interrupt
// ****************************************************
reg ref_div_ff;
always @(posedge clk) begin
    if (!rst_n)
        ref_div_ff <= 1'b0;
    else
        ref_div_ff <= refin_s ^ ref_div_ff; // Model of doubler from 25 MHz
end
wire irq_n = ~(energy_evt_ff & mcs_ff[`MCS_IRQ_MASK]);
// Clock mode drives the clock and never the interrupt
assign shared_irq_clock_pin = clk_strap_ff ? irq_n : ref_div_ff;
assign shared_irq_clock_pin_oe = 1'b1;

// ****************************************************
// Carrier sense from the receive bit stream
// ****************************************************
localparam ST_IDLE = 4'b0001;
localparam ST_PRE = 4'b0010;
localparam ST_STREAM = 4'b0100;
localparam ST_END = 4'b1000;
reg [3:0] st_ff;
reg [3:0] nxt_st;
reg [9:0] win_ff;
reg [3:0] ones_ff;
reg [2:0] bitc_ff;
reg [4:0] prev_ff;
reg sym_go_ff;
reg crs_rx;

// Zeros count over a ten-bit window
function [3:0] zeros10;
    input [9:0] w;
    integer i;
    begin
        zeros10 = 4'h0;
        for (i = 0; i < 10; i = i + 1)
            zeros10 = zeros10 + {3'b000, ~w[i]};
    end
endfunction

wire [9:0] win_n = {win_ff[8:0], rxb_s};
wire [4:0] sym_now = win_n[4:0];
// Two zeros, not adjacent, inside the span
wire start_hit = (zeros10(win_n) >= 4'h2) && !(zeros10(win_n) == 4'h2 &&
    (|(~win_n[9:1] & ~win_n[8:0])));

// Bit and symbol bookkeeping
always @(posedge clk) begin
    if (hw_in_reset || !powered) begin
        win_ff <= 10'h3ff;
        ones_ff <= 4'h0;
        bitc_ff <= 3'h0;
        prev_ff <= `SYM_IDLE;
        sym_go_ff <= 1'b0;
    end else if (rxv_s) begin
        win_ff <= win_n;
        ones_ff <= rxb_s ? ((ones_ff == 4'ha) ? 4'ha : ones_ff + 4'h1) : 4'h0;
        sym_go_ff <= (st_ff != ST_IDLE) && (bitc_ff == 3'h4 || nxt_st == ST_STREAM);
        bitc_ff <= (nxt_st != st_ff || bitc_ff == 3'h4) ? 3'h0 : bitc_ff + 3'h1;
        if (bitc_ff == 3'h4 && st_ff != ST_PRE)
            prev_ff <= sym_now;
    end
end

// Delimiter state machine
always @(*) begin
    nxt_st = st_ff;
    case (st_ff)
        ST_IDLE: if (rxv_s && start_hit) nxt_st = ST_PRE;
        ST_PRE: begin
            if (rxv_s && rxb_s && ones_ff == 4'h9)
                nxt_st = ST_IDLE;
            else if (rxv_s && win_n == {`SYM_J, `SYM_K})
                nxt_st = ST_STREAM;
        end
        ST_STREAM: begin
            if (rxv_s && bitc_ff == 3'h4 && (sym_now == `SYM_T || sym_now == `SYM_IDLE))
                nxt_st = ST_END; // Await end pair after T or first idle
        end
        ST_END: begin
            if (rxv_s && bitc_ff == 3'h4)
                nxt_st = ((prev_ff == `SYM_T && sym_now == `SYM_R) ||
                    (prev_ff == `SYM_IDLE && sym_now == `SYM_IDLE)) ? ST_IDLE : ST_STREAM;
        end
        default: nxt_st = ST_IDLE;
    endcase
end

always @(posedge clk) begin
    if (hw_in_reset || !powered)
        st_ff <= ST_IDLE;
    else
        st_ff <= nxt_st;
end

// Carrier is held through the pending end pair so a lone T keeps it
always @(*) begin
    crs_rx = (st_ff == ST_PRE) || (st_ff == ST_STREAM) || (st_ff == ST_END);
end
wire rx_only = ctl_ff[`CTL_FULL_DUPLEX] | mcs_ff[`MCS_REPEATER];
assign carrier_sense = crs_rx | (~rx_only & tx_en_gated);

// ****************************************************
// Indicators
// ****************************************************
reg [31:0] blink_cnt_ff;
reg blink_ff;
always @(posedge clk) begin
    if (!rst_n || !carrier_sense) begin
        blink_cnt_ff <= 32'h0000_0000;
        blink_ff <= 1'b1; // Steady when carrier ends
    end else if (blink_cnt_ff >= BLINK_CYCLES - 1) begin
        blink_cnt_ff <= 32'h0000_0000;
        blink_ff <= ~blink_ff;
    end else
        blink_cnt_ff <= blink_cnt_ff + 32'h0000_0001;
end
wire link_on = link_s & powered & blink_ff;
wire speed_on = ctl_ff[`CTL_SPEED_100] & ~ctl_ff[`CTL_ISOLATE] & powered;
assign link_activity_indicator = reg_strap_ff ? ~link_on : link_on;
assign speed_indicator = clk_strap_ff ? ~speed_on : speed_on;

endmodule // phy_clock_led_power_crs_control
`default_nettype wire

// *** test/phy_ctrl_props.sv ***
/* Port checker for the transceiver control block.
   Assumes binding onto the block; control bits are mirrored from port writes. */
`timescale 1ns/100ps
`default_nettype none
module phy_ctrl_props #(
    parameter integer SLOW_CYCLES = 320
) (
    // Clock and resets
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hw_reset_n,
    // Inputs
    input wire logic link_valid,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    // Outputs
    input wire logic [15:0] reg_rdata,
    input wire logic shared_irq_clock_pin_oe,
    input wire logic link_activity_indicator,
    input wire logic tx_en_gated,
    input wire logic tx_er_gated,
    input wire logic carrier_sense,
    input wire logic core_powered,
    input wire logic rmii_fast
);
    logic iso_ff;
    logic pd_ff;
    logic [9:0] run_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ****
    // Mirrors; cleared early on hardware reset, which only weakens the checks
    // ****
    always @(posedge clk) begin
        if (!rst_n || !hw_reset_n) begin
            iso_ff <= 1'b0;
            pd_ff <= 1'b0;
        end else if (reg_wr && reg_addr == 4'h0) begin
            iso_ff <= reg_wdata[2] & ~reg_wdata[0];
            pd_ff <= reg_wdata[1] & ~reg_wdata[0];
        end
    end
    // Cycles since power-on release, saturating
    always @(posedge clk) begin
        if (!rst_n) run_ff <= 10'h000;
        else if (run_ff != 10'h3ff) run_ff <= run_ff + 10'h001;
    end
    pin_drive_a: assert property (shared_irq_clock_pin_oe)
        else $error("shared pin undriven");
    tx_power_a: assert property (tx_en_gated |-> core_powered || $past(core_powered))
        else $error("transmit while powered down");
    iso_gate_a: assert property (iso_ff [*4] |-> !tx_en_gated && !tx_er_gated)
        else $error("transmit passes while isolated");
    pd_core_a: assert property (pd_ff [*4] |-> !core_powered)
        else $error("core powered in power-down");
    slow_rate_a: assert property (rmii_fast |-> run_ff >= SLOW_CYCLES - 1)
        else $error("fast rate too early");
    unmapped_zero_a: assert property (reg_rd && reg_addr > 4'h3 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!reg_rd && hw_reset_n |=> $stable(reg_rdata))
        else $error("read data changed without read");
    led_steady_a: assert property ((!carrier_sense && $stable(link_valid) && hw_reset_n
        && $stable(core_powered)) [*6] |-> $stable(link_activity_indicator))
        else $error("link indicator moves without carrier");
    cover property ($rose(carrier_sense));
    cover property ($rose(rmii_fast));
    cover property ($fell(core_powered));
endmodule // phy_ctrl_props
bind phy_clock_led_power_crs_control phy_ctrl_props #(.SLOW_CYCLES(SLOW_CYCLES)) i_props (
    .clk(clk), .rst_n(rst_n), .hw_reset_n(hw_reset_n), .link_valid(link_valid),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .shared_irq_clock_pin_oe(shared_irq_clock_pin_oe),
    .link_activity_indicator(link_activity_indicator), .tx_en_gated(tx_en_gated),
    .tx_er_gated(tx_er_gated), .carrier_sense(carrier_sense),
    .core_powered(core_powered), .rmii_fast(rmii_fast));
`default_nettype wire

// *** test/rmii_far_end.sv ***
/* Far-end model: reference clock source and encoded receive bits.
   Assumes the bench calls send_bits; bits leave msb first. */
`timescale 1ns/100ps
`default_nettype none
module rmii_far_end (
    // Clock
    input wire logic clk,
    // Toward the block
    output logic clock_input_pin,
    output logic rx_bit,
    output logic rx_bit_valid
);
    // Reference clock runs throughout, reset included
    initial begin
        clock_input_pin = 1'b0;
        forever #200 clock_input_pin = ~clock_input_pin;
    end
    initial begin
        rx_bit = 1'b1;
        rx_bit_valid = 1'b0;
    end
    // Two symbols per call; inverse shown between bits so stale data never matches
    task automatic send_bits(input logic [9:0] b);
        int i;
        for (i = 9; i >= 0; i--) begin
            @(posedge clk);
            rx_bit <= b[i];
            rx_bit_valid <= 1'b1;
            @(posedge clk);
            rx_bit <= ~b[i];
            rx_bit_valid <= 1'b0;
        end
    endtask
endmodule // rmii_far_end
`default_nettype wire

// *** test/phy_clock_led_power_crs_control_test.sv ***
/* Testbench for the transceiver control block.
   Assumes the far-end model and the bound checker; 20 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
`include "phy_ctrl_map.vh"
module phy_clock_led_power_crs_control_test;
    logic clk, rst_n, hw_reset_n, clock_pin_mode_strap, regulator_off_strap;
    logic link_valid, line_energy, tx_en, tx_er, reg_wr, reg_rd;
    logic [1:0] txd;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    wire logic clock_input_pin, rx_bit, rx_bit_valid;
    wire logic [15:0] reg_rdata;
    wire logic pin, link_ind, speed_ind, tx_en_gated, tx_er_gated, crs, pwr, fast;
    wire logic [1:0] txd_gated;
    int failures, tests_run, cycles, k, led_flips, pin_flips;
    // Short blink keeps the activity check brief
    phy_clock_led_power_crs_control #(.BLINK_CYCLES(8), .SLOW_CYCLES(320)) i_dut (
        .clk(clk), .rst_n(rst_n), .hw_reset_n(hw_reset_n),
        .clock_pin_mode_strap(clock_pin_mode_strap), .regulator_off_strap(regulator_off_strap),
        .clock_input_pin(clock_input_pin), .link_valid(link_valid), .line_energy(line_energy),
        .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .tx_en(tx_en), .txd(txd), .tx_er(tx_er),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .shared_irq_clock_pin(pin), .shared_irq_clock_pin_oe(),
        .link_activity_indicator(link_ind), .speed_indicator(speed_ind),
        .tx_en_gated(tx_en_gated), .txd_gated(txd_gated), .tx_er_gated(tx_er_gated),
        .carrier_sense(crs), .core_powered(pwr), .rmii_fast(fast));
    rmii_far_end i_far (.clk(clk), .clock_input_pin(clock_input_pin), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(link_ind) led_flips++;
    always @(pin) pin_flips++;
    // ****
    // Helpers
    // ****
    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            failures++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk((reg_rdata & m) === e, "register read");
    endtask
    task automatic results();
        if (failures == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end
    // ****
    // Main sequence
    // ****
    initial begin
        {rst_n, hw_reset_n, regulator_off_strap, link_valid, tx_en, tx_er, reg_wr, reg_rd} = 8'h00;
        {clock_pin_mode_strap, line_energy, txd, reg_addr, reg_wdata} = 24'hc0_0000;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        hw_reset_n <= 1'b1;
        settle(6);
        rd(4'h0, 16'hffff, 16'h0028);
        rd(4'h1, 16'hfffd, 16'h0000);
        rd(4'h3, 16'h0003, 16'h0001);
        wr(4'h9, 16'hffff);
        rd(4'h9, 16'hffff, 16'h0000);
        chk(pin === 1'b1 && speed_ind === 1'b0, "interrupt idle, speed on");
        @(posedge clk);
        link_valid <= 1'b1;
        tx_en <= 1'b1;
        txd <= 2'b10;
        wr(4'h0, 16'h002c);
        settle(6);
        chk(tx_en_gated === 1'b0 && speed_ind === 1'b1, "isolated");
        rd(4'h0, 16'hffff, 16'h002c);
        wr(4'h0, 16'h0028);
        settle(6);
        chk(tx_en_gated === 1'b1 && txd_gated === 2'b10 && crs === 1'b1, "tx");
        wr(4'h0, 16'h0038);
        settle(6);
        chk(crs === 1'b0, "full duplex tx");
        wr(4'h0, 16'h0028);
        wr(4'h1, 16'h0010);
        settle(6);
        chk(crs === 1'b0, "repeater tx");
        tx_en <= 1'b0;
        line_energy <= 1'b0;
        wr(4'h0, 16'h0020);
        wr(4'h1, 16'h0005);
        settle(8);
        chk(speed_ind === 1'b1 && link_ind === 1'b0, "10M, link dark while down");
        chk(pwr === 1'b0, "energy down");
        tx_en <= 1'b1;
        settle(6);
        chk(tx_en_gated === 1'b0, "silent");
        line_energy <= 1'b1;
        for (k = 0; k < 50 && pwr !== 1'b1; k++) @(posedge clk);
        settle(2);
        chk(pwr === 1'b1 && pin === 1'b0, "energy wake");
        rd(4'h1, 16'h0002, 16'h0002);
        rd(4'h2, 16'h0001, 16'h0001);
        rd(4'h2, 16'h0001, 16'h0000);
        wr(4'h0, 16'h002a);
        settle(6);
        chk(pwr === 1'b0, "power down");
        rd(4'h0, 16'hffff, 16'h002a);
        wr(4'h0, 16'h0028);
        settle(6);
        chk(pwr === 1'b1 && fast === 1'b0, "power up reset");
        // Sticky bit must outlive the soft reset, the rest must not
        wr(4'h1, 16'h0008);
        wr(4'h0, 16'h0004);
        wr(4'h0, 16'h0001);
        settle(40);
        rd(4'h0, 16'hffff, 16'h0028);
        rd(4'h1, 16'h001d, 16'h0008);
        chk(fast === 1'b0, "slow after reset");
        for (k = 0; k < 400 && fast !== 1'b1; k++) @(posedge clk);
        chk(fast === 1'b1, "fast rate");
        tx_en <= 1'b0;
        clock_pin_mode_strap <= 1'b0;
        regulator_off_strap <= 1'b1;
        hw_reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        hw_reset_n <= 1'b1;
        settle(8);
        rd(4'h3, 16'h0003, 16'h0002);
        rd(4'h1, 16'hfffd, 16'h0000);
        pin_flips = 0;
        settle(40);
        chk(pin_flips > 2, "clock out");
        chk(link_ind === 1'b0 && speed_ind === 1'b1, "polarity");
        i_far.send_bits(10'b1111110101);
        settle(4);
        chk(crs === 1'b1, "carrier on");
        i_far.send_bits(10'h3ff);
        settle(4);
        chk(crs === 1'b0, "false carrier");
        i_far.send_bits({`SYM_J, `SYM_K});
        i_far.send_bits({`SYM_T, 5'h0e});
        led_flips = 0;
        settle(40);
        chk(crs === 1'b1 && led_flips >= 2, "held, blinking");
        i_far.send_bits({`SYM_T, `SYM_R});
        settle(4);
        chk(crs === 1'b0 && link_ind === 1'b0, "end pair");
        i_far.send_bits({`SYM_J, `SYM_K});
        i_far.send_bits({`SYM_IDLE, 5'h0e});
        settle(4);
        chk(crs === 1'b1, "idle then data");
        i_far.send_bits({`SYM_IDLE, `SYM_IDLE});
        settle(4);
        chk(crs === 1'b0, "idle pair");
        results();
    end
endmodule // phy_clock_led_power_crs_control_test
`default_nettype wire
